// File: ptim_top.v
`timescale 1ns/1ps
`default_nettype none
`include "ptim_defines.vh"

// What this block does
// [RULE1] Hold writable 16-bit high threshold at 0x07
// [RULE2] Present three channel results at 0x08-0x0A
// [RULE3] Close flag bit 1 at 0x0D, 5:2 reserved
// [RULE4] Away flag bit 0 below low threshold
// [RULE5] Sunlight flag bit 6, sequence ready bit 7
// [RULE6] Answer address 0x41, identity at 0x0E
// [RULE7] Pulse selected LED at programmable duty ratio
// [RULE8] Defaults at reset, commands accepted immediately
// [RULE9] Close alert after 1-4 consecutive exceeding periods
// [RULE10] Forced mode measures only on trigger write
// [RULE11] Subtract cancellation level from raw measurement
// [RULE12] Enabled alert drives alert pin low
// [RULE13] Registers stay accessible while alert asserted
// [RULE14] Any flag rising pulls alert pin low; ready flag only when its alert bit (timing bit 12) is set
// [RULE15] Reading flags clears them, releases alert
// [RULE16] Logic output mode: pin low while close
// [RULE17] Host treats logic output as plain level
// [RULE18] No alert between thresholds, hysteresis holds
// [RULE19] Single channel result goes to its register
// [RULE20] Multiplex trigger runs LED1, LED2, LED3 sequence
// [RULE21] Sequence end sets ready flag, optional alert
// [RULE22] Host should choose window alert type
// [RULE23] Trigger bit clears itself after starting
// [RULE24] Hold low threshold at 0x06
// [RULE25] Hold cancellation level at 0x05
// [RULE26] Mode bit zero alert, one logic output
// [RULE27] Alert released cycle after flags all clear
module ptim_top #(
   parameter PERIOD_BASE = `PTIM_PERIOD_BASE,
   parameter [7:0] ID_LOW = 8'h5A, // Arbitrary identity value
   parameter [3:0] VERSION = 4'h3 // Arbitrary version value
) (
   // Clock and reset
   input wire CLK,
   input wire RESET,
   // Two-wire bus pins
   input wire SCL_IN,
   input wire SDA_IN,
   output reg SDA_OUT,
   output reg SDA_OE_N,
   // Alert pin
   output reg ALERT_OUT,
   output reg ALERT_OE_N,
   // Analog front end
   output reg MEAS_REQ,
   output reg [2:0] LED_DRIVE,
   input wire RAW_VALID,
   input wire [15:0] RAW_DATA,
   input wire SUN_PROTECT
);
   // ****************************************
   // Declarations
   // ****************************************
   localparam [3:0] S_IDLE = 4'h0, S_ADDR = 4'h1, S_AACK = 4'h2, S_CMD = 4'h3;
   localparam [3:0] S_CACK = 4'h4, S_WDATA = 4'h5, S_WACK = 4'h6, S_RDATA = 4'h7;
   localparam [3:0] S_RACK = 4'h8;
   localparam [1:0] M_IDLE = 2'h0, M_REQ = 2'h1, M_WAIT = 2'h2;
   reg [2:0] scl_s_r, sda_s_r, sun_s_r;
   reg [3:0] st_r;
   reg [3:0] cnt_r;
   reg [7:0] sh_r, tx_r, cmd_r, wlo_r;
   reg rw_r, bidx_r, mnack_r;
   reg [15:0] timing_r, control_r, cancel_r, low_thr_r, high_thr_r;
   reg [15:0] res1_r, res2_r, res3_r;
   reg [7:0] flags_r;
   reg near_r;
   reg [2:0] pers_r;
   reg [1:0] mst_r, chan_r;
   reg mpx_run_r;
   reg [18:0] tmr_r;
   reg trig_r;
   wire scl_rise = scl_s_r[1] & ~scl_s_r[2];
   wire scl_fall = ~scl_s_r[1] & scl_s_r[2];
   wire bus_start = scl_s_r[1] & scl_s_r[2] & ~sda_s_r[1] & sda_s_r[2];
   wire bus_stop = scl_s_r[1] & scl_s_r[2] & sda_s_r[1] & ~sda_s_r[2];
   wire sda_now = sda_s_r[1];
   wire force_en = control_r[`PTIM_FORCE_BIT];
   wire mpx_en = timing_r[`PTIM_MPX_EN_BIT];
   wire logic_mode = control_r[`PTIM_LOGIC_OUT_BIT];
   wire win_type = timing_r[`PTIM_ALERT_TYPE_BIT];
   wire [1:0] alert_en = timing_r[`PTIM_ALERT_EN_HI:`PTIM_ALERT_EN_LO];
   wire [1:0] led_sel = control_r[`PTIM_LED_SEL_HI:`PTIM_LED_SEL_LO];
   wire [1:0] sel_chan = (led_sel == 2'h3) ? 2'h2 : led_sel;
   wire [2:0] pers_target = {1'b0, timing_r[`PTIM_PERS_HI:`PTIM_PERS_LO]} + 3'h1;
   wire [1:0] duty = timing_r[`PTIM_DUTY_HI:`PTIM_DUTY_LO];
   // ****************************************
   // Pin synchronisers
   // ****************************************
   // Stage 0 feeds only stage 1; logic reads stages 1 and 2
   always @(posedge CLK) begin
      if (RESET) begin
         scl_s_r <= 3'h7;
         sda_s_r <= 3'h7;
         sun_s_r <= 3'h0;
      end else begin
         scl_s_r <= {scl_s_r[1:0], SCL_IN};
         sda_s_r <= {sda_s_r[1:0], SDA_IN};
         sun_s_r <= {sun_s_r[1:0], SUN_PROTECT};
      end
   end
   // ****************************************
   // Read data selection
   // ****************************************
   // Word returned for the current command code
   reg [15:0] rd_word;
   always @* begin
      case (cmd_r)
         `PTIM_CMD_TIMING: rd_word = timing_r;
         `PTIM_CMD_CONTROL: rd_word = control_r;
         `PTIM_CMD_CANCEL: rd_word = cancel_r;
         `PTIM_CMD_LOW_THR: rd_word = low_thr_r;
         `PTIM_CMD_HIGH_THR: rd_word = high_thr_r; // RULE1
         `PTIM_CMD_CH1: rd_word = res1_r; // RULE2
         `PTIM_CMD_CH2: rd_word = res2_r;
         `PTIM_CMD_CH3: rd_word = res3_r;
         `PTIM_CMD_FLAGS: rd_word = {flags_r & `PTIM_FLAG_USED, 8'h00}; // RULE3
         `PTIM_CMD_IDENT: rd_word = {4'h0, VERSION, ID_LOW}; // RULE6
         default: rd_word = 16'h0000;
      endcase
   end
   // Byte loaded after a master ACK is the other half; flags clear as their byte loads
   wire [7:0] tx_next = bidx_r ? rd_word[7:0] : rd_word[15:8];
   wire rd_flags = (cmd_r == `PTIM_CMD_FLAGS) & ~bidx_r;
   // ****************************************
   // Two-wire slave
   // ****************************************
   // Registers stay reachable whatever the alert pin does
   reg wr_commit;
   reg [7:0] flag_clr;
   always @(posedge CLK) begin // RULE13
      if (RESET) begin
         st_r <= S_IDLE;
         cnt_r <= 4'h0;
         sh_r <= 8'h00;
         tx_r <= 8'h00;
         cmd_r <= 8'h00;
         wlo_r <= 8'h00;
         rw_r <= 1'b0;
         bidx_r <= 1'b0;
         mnack_r <= 1'b0;
         SDA_OE_N <= 1'b1;
         SDA_OUT <= 1'b0;
         wr_commit <= 1'b0;
         flag_clr <= 8'h00;
      end else begin
         wr_commit <= 1'b0;
         flag_clr <= 8'h00;
         if (bus_start) begin
            st_r <= S_ADDR;
            cnt_r <= 4'h0;
            SDA_OE_N <= 1'b1;
         end else if (bus_stop) begin
            st_r <= S_IDLE;
            SDA_OE_N <= 1'b1;
         end else if (scl_rise) begin
            if (st_r == S_ADDR || st_r == S_CMD || st_r == S_WDATA) begin
               sh_r <= {sh_r[6:0], sda_now};
               cnt_r <= cnt_r + 4'h1;
            end else if (st_r == S_RDATA) begin
               cnt_r <= cnt_r + 4'h1;
            end else if (st_r == S_RACK) begin
               mnack_r <= sda_now;
            end
         end else if (scl_fall) begin
            case (st_r)
               S_ADDR: begin
                  if (cnt_r == 4'h8) begin
                     if (sh_r[7:1] == `PTIM_BUS_ADDR) begin // RULE6
                        rw_r <= sh_r[0];
                        SDA_OE_N <= 1'b0;
                        st_r <= S_AACK;
                     end else begin
                        st_r <= S_IDLE;
                     end
                  end
               end
               S_AACK: begin
                  cnt_r <= 4'h0;
                  bidx_r <= 1'b0;
                  if (rw_r) begin
                     tx_r <= {rd_word[6:0], 1'b0};
                     SDA_OE_N <= rd_word[7];
                     st_r <= S_RDATA;
                  end else begin
                     SDA_OE_N <= 1'b1;
                     st_r <= S_CMD;
                  end
               end
               S_CMD: begin
                  if (cnt_r == 4'h8) begin
                     cmd_r <= sh_r;
                     SDA_OE_N <= 1'b0;
                     st_r <= S_CACK;
                  end
               end
               S_CACK: begin
                  SDA_OE_N <= 1'b1;
                  cnt_r <= 4'h0;
                  st_r <= S_WDATA;
               end
               S_WDATA: begin
                  if (cnt_r == 4'h8) begin
                     if (!bidx_r)
                        wlo_r <= sh_r;
                     else
                        wr_commit <= 1'b1;
                     SDA_OE_N <= 1'b0;
                     st_r <= S_WACK;
                  end
               end
               S_WACK: begin
                  SDA_OE_N <= 1'b1;
                  cnt_r <= 4'h0;
                  bidx_r <= ~bidx_r;
                  st_r <= S_WDATA;
               end
               S_RDATA: begin
                  if (cnt_r == 4'h8) begin
                     SDA_OE_N <= 1'b1;
                     st_r <= S_RACK;
                  end else begin
                     SDA_OE_N <= tx_r[7];
                     tx_r <= {tx_r[6:0], 1'b0};
                  end
               end
               S_RACK: begin
                  if (mnack_r) begin
                     st_r <= S_IDLE;
                  end else begin
                     bidx_r <= ~bidx_r;
                     cnt_r <= 4'h0;
                     tx_r <= {tx_next[6:0], 1'b0};
                     SDA_OE_N <= tx_next[7];
                     st_r <= S_RDATA;
                  end
               end
               default: st_r <= S_IDLE;
            endcase
         end
         // Flags shown in a read are cleared once that byte is loaded
         if (scl_fall && st_r == S_RACK && !mnack_r && rd_flags)
            flag_clr <= flags_r; // RULE15
      end
   end
   // ****************************************
   // Writable registers
   // ****************************************
   // Word commit on the second data byte; trigger never reads back as one
   wire [15:0] wr_word = {sh_r, wlo_r};
   always @(posedge CLK) begin // RULE8
      if (RESET) begin
         timing_r <= `PTIM_TIMING_RST;
         control_r <= `PTIM_CONTROL_RST;
         cancel_r <= `PTIM_CANCEL_RST;
         low_thr_r <= `PTIM_LOW_THR_RST;
         high_thr_r <= `PTIM_HIGH_THR_RST;
         trig_r <= 1'b0;
      end else begin
         trig_r <= 1'b0;
         if (wr_commit) begin
            case (cmd_r)
               `PTIM_CMD_TIMING: timing_r <= wr_word;
               `PTIM_CMD_CONTROL: begin
                  control_r <= wr_word & ~(16'h0001 << `PTIM_TRIG_BIT); // RULE23
                  trig_r <= wr_word[`PTIM_TRIG_BIT] & wr_word[`PTIM_FORCE_BIT]; // RULE10
               end
               `PTIM_CMD_CANCEL: cancel_r <= wr_word; // RULE25
               `PTIM_CMD_LOW_THR: low_thr_r <= wr_word; // RULE24
               `PTIM_CMD_HIGH_THR: high_thr_r <= wr_word; // RULE1
               default: ;
            endcase
         end
      end
   end
   // ****************************************
   // Measurement sequencer
   // ****************************************
   // Cancelled value, floored at zero
   wire [15:0] meas_val = (RAW_DATA > cancel_r) ? RAW_DATA - cancel_r : 16'h0000; // RULE11
   wire meas_done = (mst_r == M_WAIT) & RAW_VALID;
   wire [18:0] period = PERIOD_BASE[18:0] << duty; // RULE7
   wire tick = ~force_en & (tmr_r >= period - 19'h1);
   wire seq_end = meas_done & mpx_run_r & (chan_r == 2'h2);
   always @(posedge CLK) begin
      if (RESET) begin
         mst_r <= M_IDLE;
         chan_r <= 2'h0;
         mpx_run_r <= 1'b0;
         tmr_r <= 19'h0;
         MEAS_REQ <= 1'b0;
         LED_DRIVE <= 3'h0;
         res1_r <= 16'h0000;
         res2_r <= 16'h0000;
         res3_r <= 16'h0000;
      end else begin
         MEAS_REQ <= 1'b0;
         tmr_r <= tick ? 19'h0 : tmr_r + 19'h1;
         case (mst_r)
            M_IDLE: begin
               // Forced mode waits for a trigger; normal mode runs on the timer
               if (trig_r || tick) begin // RULE10
                  mpx_run_r <= trig_r & mpx_en; // RULE20
                  chan_r <= (trig_r & mpx_en) ? 2'h0 : sel_chan;
                  mst_r <= M_REQ;
               end
            end
            M_REQ: begin
               MEAS_REQ <= 1'b1;
               LED_DRIVE <= 3'h1 << chan_r; // RULE7
               mst_r <= M_WAIT;
            end
            M_WAIT: begin
               if (RAW_VALID) begin
                  LED_DRIVE <= 3'h0;
                  case (chan_r) // RULE19
                     2'h0: res1_r <= meas_val;
                     2'h1: res2_r <= meas_val;
                     default: res3_r <= meas_val;
                  endcase
                  if (mpx_run_r && chan_r != 2'h2) begin
                     chan_r <= chan_r + 2'h1; // RULE20
                     mst_r <= M_REQ;
                  end else begin
                     mpx_run_r <= 1'b0;
                     mst_r <= M_IDLE;
                  end
               end
            end
            default: mst_r <= M_IDLE;
         endcase
      end
   end
   // ****************************************
   // Threshold detection and flags
   // ****************************************
   // Detection runs on the selected channel's result
   wire judge = meas_done & (chan_r == sel_chan);
   wire above = meas_val > high_thr_r;
   wire below = meas_val < low_thr_r;
   wire [2:0] pers_inc = (pers_r == 3'h7) ? pers_r : pers_r + 3'h1;
   reg [7:0] flag_set;
   always @* begin
      flag_set = 8'h00;
      if (judge && above && pers_inc >= pers_target && (!near_r || !win_type))
         flag_set[`PTIM_FLAG_CLOSE] = alert_en[0]; // RULE3 RULE9
      if (judge && below && (near_r || !win_type))
         flag_set[`PTIM_FLAG_AWAY] = alert_en[1]; // RULE4
      flag_set[`PTIM_FLAG_SUN] = sun_s_r[1] & ~sun_s_r[2]; // RULE5
      flag_set[`PTIM_FLAG_READY] = seq_end; // RULE21
   end
   always @(posedge CLK) begin
      if (RESET) begin
         flags_r <= 8'h00;
         near_r <= 1'b0;
         pers_r <= 3'h0;
      end else begin
         // A set in the same cycle as the read clear wins
         flags_r <= (flags_r & ~flag_clr) | flag_set; // RULE15
         if (judge) begin
            if (above) begin
               pers_r <= pers_inc;
               if (pers_inc >= pers_target)
                  near_r <= 1'b1; // RULE9
            end else if (below) begin
               pers_r <= 3'h0;
               near_r <= 1'b0;
            end else begin
               pers_r <= 3'h0; // RULE18
            end
         end
      end
   end
   // ****************************************
   // Alert pin
   // ****************************************
   // Level follows detection in logic mode, pending flags otherwise
   wire flag_alert = |(flags_r & {timing_r[`PTIM_MPX_ALERT_BIT], 7'h43}); // RULE14 RULE21
   always @(posedge CLK) begin
      if (RESET) begin
         ALERT_OE_N <= 1'b1;
         ALERT_OUT <= 1'b0;
      end else begin
         if (logic_mode)
            ALERT_OE_N <= ~near_r; // RULE16 RULE26
         else
            ALERT_OE_N <= ~flag_alert; // RULE12 RULE27
      end
   end

endmodule

`default_nettype wire

// File: ptim_defines.vh
`ifndef PTIM_DEFINES_VH
`define PTIM_DEFINES_VH

// ****************************************
// Bus address and command codes
// ****************************************
`define PTIM_BUS_ADDR 7'h41
`define PTIM_CMD_TIMING 8'h03
`define PTIM_CMD_CONTROL 8'h04
`define PTIM_CMD_CANCEL 8'h05
`define PTIM_CMD_LOW_THR 8'h06
`define PTIM_CMD_HIGH_THR 8'h07
`define PTIM_CMD_CH1 8'h08
`define PTIM_CMD_CH2 8'h09
`define PTIM_CMD_CH3 8'h0A
`define PTIM_CMD_FLAGS 8'h0D
`define PTIM_CMD_IDENT 8'h0E

// ****************************************
// Field positions
// ****************************************
// Timing register, low byte
`define PTIM_DUTY_HI 7
`define PTIM_DUTY_LO 6
`define PTIM_PERS_HI 5
`define PTIM_PERS_LO 4
`define PTIM_ALERT_EN_HI 1
`define PTIM_ALERT_EN_LO 0
// Timing register, high byte
`define PTIM_MPX_EN_BIT 13
`define PTIM_MPX_ALERT_BIT 12
`define PTIM_ALERT_TYPE_BIT 11
// Control register, low byte
`define PTIM_LED_SEL_HI 6
`define PTIM_LED_SEL_LO 5
`define PTIM_FORCE_BIT 3
`define PTIM_TRIG_BIT 2
`define PTIM_LOGIC_OUT_BIT 1
// Flag byte positions
`define PTIM_FLAG_READY 7
`define PTIM_FLAG_SUN 6
`define PTIM_FLAG_CLOSE 1
`define PTIM_FLAG_AWAY 0
`define PTIM_FLAG_USED 8'hC3

// ****************************************
// Reset values and timing
// ****************************************
`define PTIM_TIMING_RST 16'h0000
`define PTIM_CONTROL_RST 16'h0000
`define PTIM_CANCEL_RST 16'h0000
`define PTIM_LOW_THR_RST 16'h0000
`define PTIM_HIGH_THR_RST 16'hFFFF
`define PTIM_PERIOD_BASE 2000

`endif

// File: ptim_checker_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ptim_checker (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // Bus pins
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   input wire logic SDA_OUT,
   input wire logic SDA_OE_N,
   // Alert pin
   input wire logic ALERT_OUT,
   input wire logic ALERT_OE_N,
   // Front end
   input wire logic MEAS_REQ,
   input wire logic [2:0] LED_DRIVE,
   input wire logic RAW_VALID,
   input wire logic [15:0] RAW_DATA,
   input wire logic SUN_PROTECT
);
   // ****************************************
   // Clocking
   // ****************************************
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RESET);

   // ****************************************
   // Properties
   // ****************************************
   a_req_pulse: assert property (MEAS_REQ |=> !MEAS_REQ)
      else $error("measurement request longer than one cycle");
   a_led_follow: assert property (MEAS_REQ |=> $onehot(LED_DRIVE))
      else $error("no single LED after request");
   a_led_cause: assert property ($rose(LED_DRIVE != 3'h0) |-> MEAS_REQ)
      else $error("LED lit without request");
   a_led_release: assert property (RAW_VALID && LED_DRIVE != 3'h0 |=> LED_DRIVE == 3'h0)
      else $error("LED still lit after result");
   a_led_steady: assert property (LED_DRIVE != 3'h0 && !RAW_VALID |=> $stable(LED_DRIVE))
      else $error("LED changed during measurement");
   a_req_idle: assert property (MEAS_REQ |-> $past(LED_DRIVE) == 3'h0)
      else $error("request while LED lit");
   a_reset_quiet: assert property (disable iff (1'b0)
      RESET |=> SDA_OE_N && ALERT_OE_N && !MEAS_REQ && LED_DRIVE == 3'h0)
      else $error("outputs active after reset");
   a_sda_tie: assert property (SDA_OUT == 1'b0)
      else $error("data pin driven high");
   a_alert_tie: assert property (ALERT_OUT == 1'b0)
      else $error("alert pin driven high");
   a_sda_scl_low: assert property ($changed(SDA_OE_N) |-> !SCL_IN)
      else $error("data pin changed while bus clock high");
endmodule

bind ptim_top ptim_checker u_chk (.CLK(CLK), .RESET(RESET), .SCL_IN(SCL_IN),
   .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .ALERT_OUT(ALERT_OUT),
   .ALERT_OE_N(ALERT_OE_N), .MEAS_REQ(MEAS_REQ), .LED_DRIVE(LED_DRIVE),
   .RAW_VALID(RAW_VALID), .RAW_DATA(RAW_DATA), .SUN_PROTECT(SUN_PROTECT));
`default_nettype wire

// File: ptim_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module ptim_front_model #(
   parameter int DELAY = 5
) (
   // Clock
   input wire logic clk,
   // Request side
   input wire logic meas_req,
   input wire logic [2:0] led_drive,
   input wire logic [15:0] level,
   // Answer side
   output wire logic raw_valid,
   output wire logic [15:0] raw_data
);
   int cnt_r = 0;
   logic valid_r = 1'b0;
   logic [15:0] data_r = 16'h0000;
   assign raw_valid = valid_r;
   assign raw_data = data_r;
   // Answer each request after DELAY cycles, offset by lit channel
   always @(posedge clk) begin
      valid_r <= 1'b0;
      data_r <= ~data_r; // Stale data toggles between answers
      if (meas_req) begin
         cnt_r <= DELAY;
      end else if (cnt_r == 1) begin
         valid_r <= 1'b1;
         data_r <= level + {6'h00, led_drive[2], led_drive[1], 8'h00};
         cnt_r <= 0;
      end else if (cnt_r > 0) begin
         cnt_r <= cnt_r - 1;
      end
   end
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptim_defines.vh"
module testbench;
   // ****************************************
   // Signals
   // ****************************************
   logic CLK = 1'b0;
   logic RESET = 1'b1;
   logic scl = 1'b1;
   logic sda_low = 1'b0;
   logic sun = 1'b0;
   logic [15:0] level = 16'h0000;
   logic [15:0] rv;
   logic [15:0] n0;
   logic a;
   int err_total = 0;
   int tests_run = 0;
   int nreq = 0;
   wire sda_out, sda_oe_n, alert_out, alert_oe_n, meas_req, raw_valid;
   wire [2:0] led;
   wire [15:0] raw;
   wire sda = (sda_low | ~sda_oe_n) ? 1'b0 : 1'b1; // Open-drain wire with pull-up

   always #2 CLK = ~CLK;
   // Count measurement requests
   always @(posedge CLK) if (meas_req) nreq <= nreq + 1;

   ptim_top #(.PERIOD_BASE(20), .ID_LOW(8'h5A), .VERSION(4'h3)) u_dut (.CLK(CLK),
      .RESET(RESET), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
      .ALERT_OUT(alert_out), .ALERT_OE_N(alert_oe_n), .MEAS_REQ(meas_req),
      .LED_DRIVE(led), .RAW_VALID(raw_valid), .RAW_DATA(raw), .SUN_PROTECT(sun));
   ptim_front_model #(.DELAY(5)) u_fe (.clk(CLK), .meas_req(meas_req), .led_drive(led),
      .level(level), .raw_valid(raw_valid), .raw_data(raw));

   // ****************************************
   // Tasks
   // ****************************************
   task conclude;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task q;
      repeat (4) @(negedge CLK);
   endtask
   task bit_io(input logic b, output logic r);
      sda_low = ~b;
      q;
      scl = 1'b1;
      q;
      r = sda;
      q;
      scl = 1'b0;
      q;
   endtask
   task start;
      sda_low = 1'b0;
      q;
      scl = 1'b1;
      q;
      sda_low = 1'b1;
      q;
      scl = 1'b0;
      q;
   endtask
   task stop;
      sda_low = 1'b1;
      q;
      scl = 1'b1;
      q;
      sda_low = 1'b0;
      q;
   endtask
   task byte_io(input logic [7:0] t, output logic [7:0] r);
      for (int i = 7; i >= 0; i--) bit_io(t[i], r[i]);
   endtask
   // Send a byte and expect the device to acknowledge
   task send(input logic [7:0] t);
      logic [7:0] d;
      byte_io(t, d);
      bit_io(1'b1, a);
      chk("ack", 16'h0000, {15'h0000, a});
   endtask
   task wr(input logic [7:0] c, input logic [15:0] v);
      start;
      send({`PTIM_BUS_ADDR, 1'b0});
      send(c);
      send(v[7:0]);
      send(v[15:8]);
      stop;
   endtask
   // Word read: low byte, master ACK, high byte, NACK
   task rc(input logic [7:0] c, input logic [15:0] e);
      start;
      send({`PTIM_BUS_ADDR, 1'b0});
      send(c);
      start;
      send({`PTIM_BUS_ADDR, 1'b1});
      byte_io(8'hFF, rv[7:0]);
      bit_io(1'b0, a);
      byte_io(8'hFF, rv[15:8]);
      bit_io(1'b1, a);
      stop;
      chk($sformatf("reg %h", c), e, rv);
   endtask
   task meas(input logic [15:0] ctl);
      wr(8'h04, ctl);
      repeat (60) @(negedge CLK);
   endtask
   task alert(input logic e);
      chk("alert", {15'h0000, e}, {15'h0000, alert_oe_n});
   endtask

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (4) @(negedge CLK);
      RESET = 1'b0;
      repeat (4) @(negedge CLK);
      rc(8'h07, 16'hFFFF);
      rc(8'h06, 16'h0000);
      rc(8'h0D, 16'h0000);
      rc(8'h0E, 16'h035A);
      rc(8'h0B, 16'h0000);
      start;
      byte_io(8'h84, rv[7:0]);
      bit_io(1'b1, a);
      stop;
      chk("nack", 16'h0001, {15'h0000, a});
      wr(8'h04, 16'h0008);
      wr(8'h07, 16'hA55A);
      rc(8'h07, 16'hA55A);
      wr(8'h06, 16'h0100);
      rc(8'h06, 16'h0100);
      wr(8'h05, 16'h0010);
      rc(8'h05, 16'h0010);
      level = 16'h0500;
      n0 = nreq[15:0];
      repeat (200) @(negedge CLK);
      chk("idle req", n0, nreq[15:0]);
      meas(16'h002C);
      chk("req count", n0 + 16'h0001, nreq[15:0]);
      rc(8'h09, 16'h05F0);
      rc(8'h0A, 16'h0000);
      rc(8'h04, 16'h0028);
      wr(8'h07, 16'h0400);
      wr(8'h03, 16'h0811);
      level = 16'h0810;
      meas(16'h000C);
      alert(1'b1);
      meas(16'h000C);
      alert(1'b0);
      rc(8'h07, 16'h0400);
      rc(8'h0D, 16'h0200);
      alert(1'b1);
      rc(8'h0D, 16'h0000);
      wr(8'h03, 16'h0813);
      level = 16'h0210;
      meas(16'h000C);
      alert(1'b1);
      level = 16'h0060;
      meas(16'h000C);
      alert(1'b0);
      rc(8'h0D, 16'h0100);
      wr(8'h03, 16'h0810);
      level = 16'h0810;
      meas(16'h000E);
      meas(16'h000E);
      alert(1'b0);
      level = 16'h0060;
      meas(16'h000E);
      alert(1'b1);
      wr(8'h04, 16'h0008);
      wr(8'h03, 16'h3800);
      level = 16'h0300;
      n0 = nreq[15:0];
      meas(16'h000C);
      chk("req count", n0 + 16'h0003, nreq[15:0]);
      alert(1'b0);
      rc(8'h08, 16'h02F0);
      rc(8'h09, 16'h03F0);
      rc(8'h0A, 16'h04F0);
      rc(8'h0D, 16'h8000);
      sun = 1'b1;
      repeat (10) @(negedge CLK);
      alert(1'b0);
      rc(8'h0D, 16'h4000);
      // Free-running plain threshold mode at twice the base period
      level = 16'h0810;
      wr(8'h03, 16'h0041);
      wr(8'h04, 16'h0000);
      repeat (100) @(negedge CLK);
      n0 = nreq[15:0];
      repeat (400) @(negedge CLK);
      chk("period req", n0 + 16'h000A, nreq[15:0]);
      alert(1'b0);
      rc(8'h0D, 16'h0200);
      conclude;
   end

   // Watchdog against a hung bus
   initial begin
      #300000;
      err_total++;
      conclude;
   end
endmodule
`default_nettype wire
